// [core/eppt_port.v]
`timescale 1ns/1ps
`include "eppt_defines.vh"
module eppt_port (
  input  wire       CLK,
  input  wire       RESET_N,
  input  wire [1:0] MODE,
  input  wire       REVERSE,
  input  wire       TERM_COUNT,
  input  wire [7:0] TX_DATA,
  input  wire       TX_VALID,
  output reg        TX_READY,
  output reg  [7:0] RX_DATA,
  output reg        RX_VALID,
  input  wire       RX_READY,
  input  wire       BUSY_IN,
  input  wire       NACK_IN,
  input  wire       NFAULT_IN,
  input  wire [7:0] DATA_IN,
  output reg  [7:0] DATA_OUT,
  output reg  [7:0] DATA_OE_N,
  output reg        NSTROBE_OUT,
  output reg        NSTROBE_OE_N,
  output reg        NAUTOFD_OUT,
  output reg        NAUTOFD_OE_N,
  output reg        REVERSE_REQ
);

  // ************************************************************
  // Input synchronisers and filters
  // ************************************************************
  // two-stage synchronisers
  reg [2:0] sync_a;
  reg [2:0] sync_b;
  always @(posedge CLK) begin
    if (!RESET_N) begin
      // Reset to the idle pin levels so no false Busy or nAck edge follows reset.
      sync_a <= 3'h6;
      sync_b <= 3'h6;
    end else begin
      sync_a <= {NFAULT_IN, NACK_IN, BUSY_IN};
      sync_b <= sync_a;
    end
  end

  localparam integer FILT_I  = `EPPT_FILT_CYC - 1;
  localparam integer SETUP_I = `EPPT_SETUP_CYC;
  localparam integer STRB_I  = `EPPT_STRB_CYC - 1;
  localparam integer HOLD_I  = `EPPT_HOLD_CYC - 1;
  localparam integer GAP_I   = `EPPT_GAP_CYC;

  reg                  busy_f;
  reg                  nack_f;
  reg [`EPPT_CNT_W-1:0] busy_cnt;
  reg [`EPPT_CNT_W-1:0] nack_cnt;
  always @(posedge CLK) begin
    if (!RESET_N) begin
      busy_f   <= 1'b0;
      busy_cnt <= {`EPPT_CNT_W{1'b0}};
    end else if (sync_b[0] == busy_f) begin
      busy_cnt <= {`EPPT_CNT_W{1'b0}};
    end else if (busy_cnt == FILT_I[`EPPT_CNT_W-1:0]) begin
      busy_f   <= sync_b[0];
      busy_cnt <= {`EPPT_CNT_W{1'b0}};
    end else begin
      busy_cnt <= busy_cnt + 1'b1;
    end
  end
  always @(posedge CLK) begin
    if (!RESET_N) begin
      nack_f   <= 1'b1;
      nack_cnt <= {`EPPT_CNT_W{1'b0}};
    end else if (sync_b[1] == nack_f) begin
      nack_cnt <= {`EPPT_CNT_W{1'b0}};
    end else if (nack_cnt == FILT_I[`EPPT_CNT_W-1:0]) begin
      nack_f   <= sync_b[1];
      nack_cnt <= {`EPPT_CNT_W{1'b0}};
    end else begin
      nack_cnt <= nack_cnt + 1'b1;
    end
  end

  // ************************************************************
  // Two-entry reverse buffer
  // ************************************************************
  // A stall by the consumer fills this buffer, which then stalls the cable.
  reg [7:0] buf_mem [0:1];
  reg       buf_wp;
  reg       buf_rp;
  reg [1:0] buf_cnt;
  wire      buf_push;
  wire      buf_pop = RX_VALID && RX_READY;
  wire      buf_full = (buf_cnt == 2'h2);
  always @(posedge CLK) begin
    if (!RESET_N) begin
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wp] <= DATA_IN;
        buf_wp          <= ~buf_wp;
      end
      if (buf_pop)
        buf_rp <= ~buf_rp;
      buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end
  always @(posedge CLK) begin
    if (!RESET_N) begin
      RX_VALID <= 1'b0;
      RX_DATA  <= 8'h00;
    end else begin
      RX_VALID <= (buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop}) != 2'h0;
      RX_DATA  <= (buf_cnt - {1'b0, buf_pop}) == 2'h0 ? DATA_IN :
                  buf_mem[buf_rp ^ buf_pop];
    end
  end

  // ************************************************************
  // Handshake state machine
  // ************************************************************
  localparam [7:0] ST_IDLE  = 8'h01;
  localparam [7:0] ST_SETUP = 8'h02;
  localparam [7:0] ST_STRB  = 8'h04;
  localparam [7:0] ST_WACK  = 8'h08;
  localparam [7:0] ST_WEND  = 8'h10;
  localparam [7:0] ST_RIDLE = 8'h20;
  localparam [7:0] ST_RACK  = 8'h40;
  localparam [7:0] ST_RTAKE = 8'h80;

  reg [7:0]             state;
  reg [7:0]             next_state;
  reg [`EPPT_CNT_W-1:0] tmr;
  reg [`EPPT_CNT_W-1:0] next_tmr;
  reg [`EPPT_CNT_W-1:0] gap;
  reg [7:0]             hold_data;
  reg [7:0]             next_hold_data;
  reg                   strobe_n;
  reg                   next_strobe_n;
  reg                   autofd_n;
  reg                   next_autofd_n;
  reg                   take;
  reg                   push;
  wire                  fifo_mode = (MODE == `EPPT_MODE_FIFO);
  wire                  ecp_mode  = (MODE == `EPPT_MODE_ECP);
  wire                  tmr_done  = (tmr == {`EPPT_CNT_W{1'b0}});
  assign buf_push = push;

  // gap counter after Busy goes inactive
  always @(posedge CLK) begin
    if (!RESET_N)
      gap <= {`EPPT_CNT_W{1'b0}};
    else if (busy_f)
      gap <= GAP_I[`EPPT_CNT_W-1:0];
    else if (gap != {`EPPT_CNT_W{1'b0}})
      gap <= gap - 1'b1;
  end

  always @* begin
    next_state     = state;
    next_tmr       = tmr_done ? tmr : tmr - 1'b1;
    next_hold_data = hold_data;
    next_strobe_n  = strobe_n;
    next_autofd_n  = autofd_n;
    take           = 1'b0;
    push           = 1'b0;
    case (state)
      ST_IDLE: begin
        next_strobe_n = 1'b1;
        if (TX_VALID && TX_READY) begin
          take           = 1'b1;
          next_hold_data = TX_DATA;
          next_tmr       = fifo_mode ? SETUP_I[`EPPT_CNT_W-1:0] : {`EPPT_CNT_W{1'b0}};
          next_state     = ST_SETUP;
        end else if (ecp_mode && REVERSE) begin
          next_state = ST_RIDLE;
        end
      end
      ST_SETUP: begin
        // strobe once Busy low and data stable; FIFO gap after Busy
        if (tmr_done && !busy_f && (ecp_mode || gap == {`EPPT_CNT_W{1'b0}})) begin
          next_strobe_n = 1'b0;
          next_tmr      = fifo_mode ? STRB_I[`EPPT_CNT_W-1:0] : {`EPPT_CNT_W{1'b0}};
          next_state    = fifo_mode ? ST_STRB : ST_WACK;
        end
      end
      ST_STRB: begin
        // minimum strobe width; nAck not consulted
        if (tmr_done) begin
          next_strobe_n = 1'b1;
          next_tmr      = HOLD_I[`EPPT_CNT_W-1:0];
          next_state    = ST_WEND;
        end
      end
      ST_WACK: begin
        if (busy_f) begin
          next_strobe_n = 1'b1;
          next_state    = ST_WEND;
        end
      end
      ST_WEND: begin
        // hold data until Busy low and hold time; then restart
        if (!busy_f && tmr_done)
          next_state = ST_IDLE;
      end
      ST_RIDLE: begin
        next_autofd_n = 1'b0;
        if (!REVERSE || !ecp_mode) begin
          next_state = ST_IDLE;
        // acknowledge once nAck falls; stall while full or counted out
        end else if (!nack_f && !buf_full && !TERM_COUNT) begin
          push          = 1'b1;
          next_autofd_n = 1'b1;
          next_state    = ST_RACK;
        end
      end
      ST_RACK: begin
        if (nack_f)
          next_state = ST_RTAKE;
      end
      ST_RTAKE: begin
        // end transfer; ready for next byte
        next_autofd_n = 1'b0;
        next_state    = ST_RIDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      state     <= ST_IDLE;
      tmr       <= {`EPPT_CNT_W{1'b0}};
      hold_data <= 8'h00;
      strobe_n  <= 1'b1;
      autofd_n  <= 1'b0;
    end else begin
      state     <= next_state;
      tmr       <= next_tmr;
      hold_data <= next_hold_data;
      strobe_n  <= next_strobe_n;
      autofd_n  <= next_autofd_n;
    end
  end

  // ************************************************************
  // Registered pin drivers
  // ************************************************************
  // Enables and levels change in the same edge, so no pin glitches on a mode switch.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      TX_READY     <= 1'b0;
      DATA_OUT     <= 8'h00;
      DATA_OE_N    <= 8'hff;
      NSTROBE_OUT  <= 1'b1;
      NSTROBE_OE_N <= 1'b1;
      NAUTOFD_OUT  <= 1'b1;
      NAUTOFD_OE_N <= 1'b1;
      REVERSE_REQ  <= 1'b0;
    end else begin
      // Ready promises a take at the next edge; Busy and gap waits happen after it.
      TX_READY    <= (next_state == ST_IDLE) && !take && (fifo_mode || ecp_mode) &&
                     !(ecp_mode && REVERSE);
      DATA_OUT    <= next_hold_data;
      // data driven outside reverse states; nStrobe active in ECP, open-collector otherwise
      DATA_OE_N    <= (next_state == ST_RIDLE || next_state == ST_RACK ||
                       next_state == ST_RTAKE) ? 8'hff : 8'h00;
      NSTROBE_OUT  <= ecp_mode ? next_strobe_n : 1'b0;
      NSTROBE_OE_N <= ecp_mode ? 1'b0 : next_strobe_n;
      NAUTOFD_OUT  <= ecp_mode ? next_autofd_n : 1'b0;
      NAUTOFD_OE_N <= ecp_mode ? 1'b0 : 1'b1;
      REVERSE_REQ <= !sync_b[2];
    end
  end

endmodule

// [inc/eppt_defines.vh]
// Contract
// - FIFO mode ignores nAck; next byte starts from Busy only.
// - FIFO mode forwards DMA-fed bytes at up to about 500 KB/s.
// - Forward idle: nStrobe held high; peripheral keeps Busy low.
// - Forward: Busy low and data stable, then drive nStrobe low.
// - After Busy seen high, return nStrobe high.
// - Reverse idle: peripheral keeps nAck high, device keeps nAutoFd low.
// - Reverse: after previous byte taken, drive nAutoFd low.
// - After nAck falls and ready, raise nAutoFd to acknowledge.
// - After capturing reverse byte, drive nAutoFd low again.
// - Active drivers in ECP, open-collector in compatible, glitch-free switching; data lines are driven in every mode outside reverse states.
// - FIFO mode holds data until Busy inactive or 450 ns, later wins.
// - FIFO mode strobe low at least 600 ns; 680 ns after Busy.
// - Busy transition valid only after stable for 75 to 130 ns.
// - nAck transition valid only after stable for 75 to 130 ns.
// - Next strobe within 200 ns of Busy falling when FIFO holds data; ECP mode takes 280 ns, FIFO mode waits the 680 ns gap after Busy instead.
// - Reverse stalls by holding nAutoFd low when FIFO full or terminal count.
`ifndef EPPT_DEFINES_VH
`define EPPT_DEFINES_VH
`define EPPT_CLK_NS       40
`define EPPT_FILT_NS      75
`define EPPT_FILT_CYC     ((`EPPT_FILT_NS + `EPPT_CLK_NS - 1) / `EPPT_CLK_NS)
`define EPPT_SETUP_NS     600
`define EPPT_SETUP_CYC    ((`EPPT_SETUP_NS + `EPPT_CLK_NS - 1) / `EPPT_CLK_NS)
`define EPPT_STRB_NS      600
`define EPPT_STRB_CYC     ((`EPPT_STRB_NS + `EPPT_CLK_NS - 1) / `EPPT_CLK_NS)
`define EPPT_HOLD_NS      450
`define EPPT_HOLD_CYC     ((`EPPT_HOLD_NS + `EPPT_CLK_NS - 1) / `EPPT_CLK_NS)
`define EPPT_GAP_NS       680
`define EPPT_GAP_CYC      ((`EPPT_GAP_NS + `EPPT_CLK_NS - 1) / `EPPT_CLK_NS)
`define EPPT_CNT_W        5
`define EPPT_MODE_COMPAT  2'h0
`define EPPT_MODE_FIFO    2'h1
`define EPPT_MODE_ECP     2'h2
`endif

// [dv/eppt_port_assertions.sv]
`timescale 1ns/1ps
`include "eppt_defines.vh"
// ****************
// Port checker
// ****************
module eppt_assertions (
  input wire       CLK,
  input wire       RESET_N,
  input wire [1:0] MODE,
  input wire       REVERSE,
  input wire       BUSY_IN,
  input wire       NACK_IN,
  input wire       NFAULT_IN,
  input wire [7:0] DATA_OUT,
  input wire       NSTROBE_OUT,
  input wire       NSTROBE_OE_N,
  input wire       NAUTOFD_OUT,
  input wire       NAUTOFD_OE_N,
  input wire       REVERSE_REQ
);
  wire      stb  = NSTROBE_OE_N | NSTROBE_OUT;
  wire      afd  = NAUTOFD_OE_N | NAUTOFD_OUT;
  wire      ecp  = MODE == `EPPT_MODE_ECP;
  wire      fifo = MODE == `EPPT_MODE_FIFO;
  reg [5:0] busy_lo = 6'h00;
  // Saturates so a long idle never wraps into a false short gap.
  always @(posedge CLK)
    busy_lo <= BUSY_IN ? 6'h00 : busy_lo + {5'h00, busy_lo != 6'h3f};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence low15; !stb [*8] ##1 !stb [*7] ##1 stb; endsequence
  sequence hold12; $stable(DATA_OUT) [*8] ##1 $stable(DATA_OUT) [*4]; endsequence
  a_strobe_width: assert property (fifo && $fell(stb) |-> low15)
    else $error("strobe width");
  a_data_hold: assert property (fifo && $rose(stb) |-> hold12)
    else $error("data hold");
  a_strobe_gap: assert property (fifo && $fell(stb) |-> busy_lo >= `EPPT_GAP_CYC)
    else $error("strobe gap");
  a_ecp_release: assert property (ecp && $rose(stb) |-> $past(BUSY_IN, 2) && $past(BUSY_IN, 3))
    else $error("strobe rise");
  a_ack_rise: assert property (ecp && REVERSE && $rose(afd) |->
    !$past(NACK_IN, 2) && !$past(NACK_IN, 3)) else $error("ack rise");
  a_ack_fall: assert property (ecp && REVERSE && $past(REVERSE) && $fell(afd) |->
    $past(NACK_IN, 2) && $past(NACK_IN, 3)) else $error("ack fall");
  a_fault_req: assert property (REVERSE_REQ == !$past(NFAULT_IN, 3))
    else $error("fault req");
  a_driver_kind: assert property ($past(RESET_N) && $past(MODE) == MODE |-> (ecp ?
    !NSTROBE_OE_N && !NAUTOFD_OE_N : NAUTOFD_OE_N && (NSTROBE_OE_N || !NSTROBE_OUT)))
    else $error("driver kind");
endmodule
bind eppt_port eppt_assertions chk_i (.*);

// [dv/eppt_periph.sv]
`timescale 1ns/1ps
// ****************
// Peripheral model
// ****************
module eppt_periph (
  input  wire       clk,
  input  wire       strobe_n,
  input  wire       autofd_n,
  input  wire [7:0] cable,
  input  wire       rev,
  input  wire       fifo,
  input  wire       fault,
  input  wire [2:0] lag,
  output reg        busy = 1'b0,
  output reg        nack = 1'b1,
  output reg        nfault = 1'b1,
  output reg  [7:0] drive = 8'h00,
  output reg  [7:0] got = 8'h00,
  output reg        got_stb = 1'b0
);
  reg  [3:0] w = 4'h0;
  reg  [7:0] k = 8'h00;
  wire       fstep = !rev && (busy ? strobe_n : !strobe_n);
  wire       rstep = rev && (nack ? !autofd_n : autofd_n);
  wire       fire = w >= {1'b0, lag};
  always @(posedge clk) begin
    nfault  <= !fault;
    got_stb <= 1'b0;
    // Data before clock. Released lines toggle so stale data never passes.
    drive   <= rev ? k * 8'h1d + 8'h3c : ~drive;
    w       <= (fstep || rstep) && !fire ? w + 4'h1 : 4'h0;
    if (!rev)
      nack <= !fifo || !nack;
    if (fstep && fire) begin
      busy    <= !busy;
      got     <= cable;
      got_stb <= busy;
    end
    if (rstep && fire) begin
      nack <= !nack;
      k    <= k + {7'h00, !nack};
    end
  end
endmodule

// [dv/eppt_port_test.sv]
`timescale 1ns/1ps
`include "eppt_defines.vh"
// ****************
// Port testbench
// ****************
module eppt_port_test;
  reg        clk = 1'b0;
  reg        reset_n = 1'b0;
  reg  [1:0] mode = `EPPT_MODE_COMPAT;
  reg        reverse = 1'b0;
  reg        term_count = 1'b0;
  reg  [7:0] tx_data = 8'h00;
  reg        tx_valid = 1'b0;
  reg        rx_ready = 1'b0;
  reg        hold_rx = 1'b1;
  reg        fault = 1'b0;
  reg  [2:0] lag = 3'h1;
  reg [31:0] seed = 32'hac92dc74;
  integer    errors = 0;
  integer    check_count = 0;
  integer    cycles = 0;
  integer    rk = 0;
  integer    snap = 0;
  reg  [7:0] q[$];
  wire       tx_ready, rx_valid, reverse_req, busy, nack, nfault, got_stb;
  wire       nso, nse, nao, nae;
  wire [7:0] rx_data, data_out, data_oe_n, drive, got;
  wire       stb = nse | nso;
  wire       afd = nae | nao;
  wire [7:0] cable = (data_oe_n & drive) | (~data_oe_n & data_out);
  eppt_port uut (.CLK(clk), .RESET_N(reset_n), .MODE(mode), .REVERSE(reverse),
    .TERM_COUNT(term_count), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .BUSY_IN(busy),
    .NACK_IN(nack), .NFAULT_IN(nfault), .DATA_IN(cable), .DATA_OUT(data_out),
    .DATA_OE_N(data_oe_n), .NSTROBE_OUT(nso), .NSTROBE_OE_N(nse), .NAUTOFD_OUT(nao),
    .NAUTOFD_OE_N(nae), .REVERSE_REQ(reverse_req));
  eppt_periph peer (.clk(clk), .strobe_n(stb), .autofd_n(afd), .cable(cable),
    .rev(reverse), .fifo(mode == `EPPT_MODE_FIFO), .fault(fault), .lag(lag), .busy(busy),
    .nack(nack), .nfault(nfault), .drive(drive), .got(got), .got_stb(got_stb));
  function automatic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function automatic [7:0] rb(input integer n);
    rb = 8'(n * 29 + 60);
  endfunction
  task chk(input [7:0] a, input [7:0] e);
    check_count = check_count + 1;
    if (a !== e) begin
      errors = errors + 1;
      $display("CHECK FAILED %0t %h %h", $time, a, e);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Edge bytes first, then random ones at a random peripheral pace.
  task fwd(input integer n);
    integer   i;
    reg [7:0] v;
    for (i = 0; i < n; i = i + 1) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'(rnd());
      tx_data  <= v;
      tx_valid <= 1'b1;
      lag      <= 3'(rnd() % 6);
      @(negedge clk);
      while (tx_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      q.push_back(v);
    end
    tx_valid <= 1'b0;
    while (q.size() > 0 || tx_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    rx_ready <= !hold_rx && rnd() > 32'h7fffffff;
    cycles = cycles + 1;
    if (cycles > 20000) begin
      errors = errors + 1;
      conclude;
    end
  end
  always @(negedge clk) begin
    if (got_stb === 1'b1)
      chk(got, q.pop_front());
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      chk(rx_data, rb(rk));
      rk = rk + 1;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    reset_n  <= 1'b1;
    tx_valid <= 1'b1;
    fault    <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk({6'h00, tx_ready, reverse_req}, 8'h01);
    chk({6'h00, stb, afd}, 8'h03);
    @(posedge clk);
    tx_valid <= 1'b0;
    fault    <= 1'b0;
    mode     <= `EPPT_MODE_FIFO;
    @(posedge clk);
    fwd(12);
    mode <= `EPPT_MODE_ECP;
    @(posedge clk);
    fwd(24);
    reverse <= 1'b1; // direction set first
    repeat (80) @(posedge clk);
    #1;
    chk({6'h00, afd, nack}, 8'h00);
    hold_rx <= 1'b0;
    while (rk < 10) @(posedge clk);
    term_count <= 1'b1;
    repeat (40) @(posedge clk);
    snap = rk;
    repeat (40) @(posedge clk);
    chk(8'(rk), 8'(snap));
    term_count <= 1'b0;
    while (rk < snap + 4) @(posedge clk);
    conclude;
  end
endmodule
